/* File: ofc_cfg.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef OFC_CFG_SVH
`define OFC_CFG_SVH

// Register byte offsets on the APB
`define OFC_ADDR_THRESH   8'h00
`define OFC_ADDR_HOLD     8'h04
`define OFC_ADDR_CLKCTL   8'h08
`define OFC_ADDR_FLAGS    8'h0C
`define OFC_ADDR_INT_STAT 8'h10
`define OFC_ADDR_INT_CLR  8'h14
`define OFC_ADDR_INT_EN   8'h18

// Clock-out control field positions
`define OFC_CLK_OVR_BIT   0
`define OFC_CLK_SEL_LSB   1
`define OFC_CLK_SEL_MSB   2
`define OFC_CLK_DIS_BIT   3

// Flags register field positions
`define OFC_FLG_MODE_LSB  3
`define OFC_FLG_MODE_MSB  4
`define OFC_FLG_ACT_BIT   5

// Reset values
`define OFC_RST_THRESH    9'h1FF
`define OFC_RST_HOLD      16'h0001
`define OFC_RST_INT_EN    3'h0

// Sample-clock cycles per half period of the synthesizer reference
`define OFC_REF_HALF_CYC  8'h01

`endif

/* File: ofc_pkg.sv */
// Types shared by the over-range flag and clock-out block
package ofc_pkg;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } ofc_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } ofc_apb_rsp_t;

  // Channel C output selection codes
  typedef enum logic [1:0] {
    OFC_CLK_FLAG = 2'b00,
    OFC_CLK_DIV1 = 2'b01,
    OFC_CLK_DIV2 = 2'b10,
    OFC_CLK_DIV4 = 2'b11
  } ofc_clk_mode_t;

  typedef enum logic [1:0] {
    OFC_PH_RESET = 2'b00,
    OFC_PH_RUN   = 2'b01
  } ofc_phase_t;

endpackage

/* File: ofc_hold_ctr.sv */
// One channel's over-range detector with minimum hold length
`timescale 1ns/100ps
`include "ofc_cfg.svh"

module ofc_hold_ctr import ofc_pkg::*; #(
  parameter int MAG_W  = 9,
  parameter int HOLD_W = 16
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              chanEnable,
  input  wire logic [MAG_W-1:0]  magnitude,
  input  wire logic [MAG_W-1:0]  threshold,
  input  wire logic [HOLD_W-1:0] holdLength,
  output logic                   rangeFlag,
  output logic                   flagRise
);

  typedef struct packed {
    logic [HOLD_W-1:0] cnt;
    logic              flag;
  } ofc_hold_state_t;

  ofc_hold_state_t state_q;
  ofc_hold_state_t state_d;
  logic            above;

  assign above = chanEnable && (magnitude > threshold);

  always_comb begin
    state_d = state_q;
    if (above) begin
      // A length of zero behaves as one cycle
      state_d.flag = 1'b1;
      state_d.cnt  = (holdLength == '0) ? '0
                     : HOLD_W'(holdLength - 1'b1);
    end else if (state_q.cnt != '0) begin
      state_d.flag = 1'b1;
      state_d.cnt  = HOLD_W'(state_q.cnt - 1'b1);
    end else begin
      state_d.flag = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign rangeFlag = state_q.flag;
  assign flagRise  = state_d.flag && !state_q.flag;

  default clocking cbh @(posedge clk); endclocking
  default disable iff (rst);

  property p_hold_min;
    $rose(rangeFlag) && holdLength >= HOLD_W'(2) && $stable(holdLength)
      |-> ##1 rangeFlag;
  endproperty
  a_hold_min: assert property (p_hold_min)
    else $error("flag dropped before hold length");

  property p_release;
    rangeFlag && !above && state_q.cnt == '0 |=> !rangeFlag;
  endproperty
  a_release: assert property (p_release)
    else $error("flag did not drop after hold");

endmodule

/* File: ofc_overrange_mux.sv */
// Over-range flag outputs with channel C clock-out multiplexer
//
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/100ps
`include "ofc_cfg.svh"

module ofc_overrange_mux import ofc_pkg::*; #(
  parameter int NUM_CH = 4,
  parameter int MAG_W  = 9,
  parameter int HOLD_W = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire ofc_apb_req_t     apbReq,
  output ofc_apb_rsp_t          apbRsp,
  input  wire logic [MAG_W-1:0] chanAMagnitude,
  input  wire logic [MAG_W-1:0] chanBMagnitude,
  input  wire logic [MAG_W-1:0] chanCMagnitude,
  input  wire logic             clk_out_select_bit0,
  input  wire logic             clk_out_select_bit1,
  input  wire logic             synthEnable,
  input  wire logic             powerdown_pin,
  output logic                  chan_a_range_flag,
  output logic                  chan_b_range_flag,
  output logic                  chan_c_range_flag_or_clk,
  output logic                  synth_ref_out,
  output logic                  irq
);

  localparam logic CH_B_ON = (NUM_CH >= 2);
  localparam logic CH_C_ON = (NUM_CH == 4);

  typedef struct packed {
    ofc_phase_t        phase;
    logic [MAG_W-1:0]  overrange_threshold;
    logic [HOLD_W-1:0] overrange_hold_length;
    logic              clkOvr;
    ofc_clk_mode_t     clkSelReg;
    logic              clkDis;
    ofc_clk_mode_t     strapSel;
    logic [2:0]        intStat;
    logic [2:0]        intEn;
    logic [7:0]        refDiv;
    logic [2:0]        refCnt;
    logic              outC;
    logic [31:0]       rdata;
    logic              slvErr;
  } ofc_top_state_t;

  ofc_top_state_t state_q;
  ofc_top_state_t state_d;

  logic          flagA;
  logic          flagB;
  logic          flagC;
  logic [2:0]    rise;
  ofc_clk_mode_t clk_out_select;
  logic          refRun;
  logic          clkActive;
  logic          refBit;
  logic          setupRd;
  logic          setupAny;
  logic          accWr;
  logic          mapped;
  logic [7:0]    addr;

  // Per-channel detectors; absent channels are held off
  ofc_hold_ctr #(
    .MAG_W  (MAG_W),
    .HOLD_W (HOLD_W)
  ) u_hold_a (
    .clk        (clk),
    .rst        (rst),
    .chanEnable (1'b1),
    .magnitude  (chanAMagnitude),
    .threshold  (state_q.overrange_threshold),
    .holdLength (state_q.overrange_hold_length),
    .rangeFlag  (flagA),
    .flagRise   (rise[0])
  );

  ofc_hold_ctr #(
    .MAG_W  (MAG_W),
    .HOLD_W (HOLD_W)
  ) u_hold_b (
    .clk        (clk),
    .rst        (rst),
    .chanEnable (CH_B_ON),
    .magnitude  (chanBMagnitude),
    .threshold  (state_q.overrange_threshold),
    .holdLength (state_q.overrange_hold_length),
    .rangeFlag  (flagB),
    .flagRise   (rise[1])
  );

  ofc_hold_ctr #(
    .MAG_W  (MAG_W),
    .HOLD_W (HOLD_W)
  ) u_hold_c (
    .clk        (clk),
    .rst        (rst),
    .chanEnable (CH_C_ON),
    .magnitude  (chanCMagnitude),
    .threshold  (state_q.overrange_threshold),
    .holdLength (state_q.overrange_hold_length),
    .rangeFlag  (flagC),
    .flagRise   (rise[2])
  );

  // Software override takes the selection away from the straps
  assign clk_out_select = state_q.clkOvr ? state_q.clkSelReg
                                         : state_q.strapSel;
  // Reference runs only with the synthesizer on and no power-down
  assign refRun = synthEnable && !powerdown_pin;
  assign clkActive = (clk_out_select != OFC_CLK_FLAG)
                     && !state_q.clkDis
                     && refRun
                     && (state_q.phase == OFC_PH_RUN);

  always_comb begin
    case (clk_out_select)
      OFC_CLK_DIV1: refBit = state_q.refCnt[0];
      OFC_CLK_DIV2: refBit = state_q.refCnt[1];
      OFC_CLK_DIV4: refBit = state_q.refCnt[2];
      default:      refBit = 1'b0;
    endcase
  end

  // APB decode: read data is latched in setup, writes land in access
  assign addr     = apbReq.paddr;
  assign setupAny = apbReq.psel && !apbReq.penable;
  assign setupRd  = setupAny && !apbReq.pwrite;
  assign accWr    = apbReq.psel && apbReq.penable && apbReq.pwrite;

  always_comb begin
    if (addr == `OFC_ADDR_THRESH) begin
      mapped = 1'b1;
    end else if (addr == `OFC_ADDR_HOLD) begin
      mapped = 1'b1;
    end else if (addr == `OFC_ADDR_CLKCTL) begin
      mapped = 1'b1;
    end else if (addr == `OFC_ADDR_FLAGS) begin
      mapped = 1'b1;
    end else if (addr == `OFC_ADDR_INT_STAT) begin
      mapped = 1'b1;
    end else if (addr == `OFC_ADDR_INT_CLR) begin
      mapped = 1'b1;
    end else if (addr == `OFC_ADDR_INT_EN) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end

  always_comb begin
    state_d = state_q;

    case (state_q.phase)
      OFC_PH_RESET: begin
        // Straps are caught on the first edge after reset release
        state_d.strapSel = ofc_clk_mode_t'({clk_out_select_bit1,
                                            clk_out_select_bit0});
        state_d.phase    = OFC_PH_RUN;
      end
      OFC_PH_RUN: begin
        state_d.phase = OFC_PH_RUN;
      end
      default: begin
        state_d.phase = OFC_PH_RESET;
      end
    endcase

    // Reference divider chain, cleared while stopped
    if (!refRun) begin
      state_d.refDiv = 8'h00;
      state_d.refCnt = 3'h0;
    end else if (state_q.refDiv == 8'(`OFC_REF_HALF_CYC - 8'h01)) begin
      state_d.refDiv = 8'h00;
      state_d.refCnt = 3'(state_q.refCnt + 3'h1);
    end else begin
      state_d.refDiv = 8'(state_q.refDiv + 8'h01);
    end

    // Channel C pin: clock when active, otherwise its flag
    if (clkActive) begin
      state_d.outC = refBit;
    end else begin
      state_d.outC = CH_C_ON && flagC;
    end

    // Read data and error captured in the setup cycle
    if (setupAny) begin
      state_d.slvErr = !mapped;
    end
    if (setupRd) begin
      if (addr == `OFC_ADDR_THRESH) begin
        state_d.rdata = 32'(state_q.overrange_threshold);
      end else if (addr == `OFC_ADDR_HOLD) begin
        state_d.rdata = 32'(state_q.overrange_hold_length);
      end else if (addr == `OFC_ADDR_CLKCTL) begin
        state_d.rdata = 32'({state_q.clkDis, state_q.clkSelReg,
                             state_q.clkOvr});
      end else if (addr == `OFC_ADDR_FLAGS) begin
        state_d.rdata = 32'({clkActive, clk_out_select,
                             flagC, flagB, flagA});
      end else if (addr == `OFC_ADDR_INT_STAT) begin
        state_d.rdata = 32'(state_q.intStat);
      end else if (addr == `OFC_ADDR_INT_EN) begin
        state_d.rdata = 32'(state_q.intEn);
      end else begin
        state_d.rdata = 32'h0000_0000;
      end
    end

    // Register writes
    if (accWr) begin
      if (addr == `OFC_ADDR_THRESH) begin
        state_d.overrange_threshold = apbReq.pwdata[MAG_W-1:0];
      end else if (addr == `OFC_ADDR_HOLD) begin
        state_d.overrange_hold_length = apbReq.pwdata[HOLD_W-1:0];
      end else if (addr == `OFC_ADDR_CLKCTL) begin
        state_d.clkOvr    = apbReq.pwdata[`OFC_CLK_OVR_BIT];
        state_d.clkSelReg = ofc_clk_mode_t'(
          apbReq.pwdata[`OFC_CLK_SEL_MSB:`OFC_CLK_SEL_LSB]);
        state_d.clkDis    = apbReq.pwdata[`OFC_CLK_DIS_BIT];
      end else if (addr == `OFC_ADDR_INT_EN) begin
        state_d.intEn = apbReq.pwdata[2:0];
      end
    end

    // Sticky events: a new rise wins over a clear in the same cycle
    state_d.intStat = state_q.intStat | rise;
    if (accWr && addr == `OFC_ADDR_INT_CLR) begin
      state_d.intStat = (state_q.intStat & ~apbReq.pwdata[2:0]) | rise;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q                       <= '0;
      state_q.phase                 <= OFC_PH_RESET;
      state_q.overrange_threshold   <= MAG_W'(`OFC_RST_THRESH);
      state_q.overrange_hold_length <= HOLD_W'(`OFC_RST_HOLD);
      state_q.intEn                 <= `OFC_RST_INT_EN;
    end else begin
      state_q <= state_d;
    end
  end

  assign apbRsp.prdata  = state_q.rdata;
  assign apbRsp.pready  = 1'b1;
  assign apbRsp.pslverr = state_q.slvErr && apbReq.psel && apbReq.penable;

  assign chan_a_range_flag        = flagA;
  assign chan_b_range_flag        = CH_B_ON && flagB;
  assign chan_c_range_flag_or_clk = state_q.outC;
  assign synth_ref_out            = state_q.refCnt[0];
  assign irq = |(state_q.intStat & state_q.intEn);

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_flag_a_rise;
    chanAMagnitude > state_q.overrange_threshold
      |=> chan_a_range_flag;
  endproperty
  a_flag_a_rise: assert property (p_flag_a_rise)
    else $error("channel A flag missed an excursion");

  property p_flag_b_absent;
    !CH_B_ON |-> !chan_b_range_flag;
  endproperty
  a_flag_b_absent: assert property (p_flag_b_absent)
    else $error("channel B flag active on single variant");

  property p_flag_c_absent;
    !CH_C_ON && !clkActive |=> !chan_c_range_flag_or_clk;
  endproperty
  a_flag_c_absent: assert property (p_flag_c_absent)
    else $error("channel C flag active on small variant");

  property p_flag_c_path;
    !clkActive |=> chan_c_range_flag_or_clk == (CH_C_ON && $past(flagC));
  endproperty
  a_flag_c_path: assert property (p_flag_c_path)
    else $error("channel C pin does not carry its flag");

  property p_clk_div1;
    clkActive && clk_out_select == OFC_CLK_DIV1
      |=> chan_c_range_flag_or_clk == $past(state_q.refCnt[0]);
  endproperty
  a_clk_div1: assert property (p_clk_div1)
    else $error("undivided clock wrong on channel C");

  property p_clk_div4;
    clkActive && clk_out_select == OFC_CLK_DIV4
      |=> chan_c_range_flag_or_clk == $past(state_q.refCnt[2]);
  endproperty
  a_clk_div4: assert property (p_clk_div4)
    else $error("divide by four clock wrong on channel C");

  property p_powerdown;
    powerdown_pin [*2] |-> !synth_ref_out && !clkActive
      && (!chan_c_range_flag_or_clk || CH_C_ON);
  endproperty
  a_powerdown: assert property (p_powerdown)
    else $error("clock still running in power-down");

  property p_strap;
    $fell(rst) ##1 !state_q.clkOvr |->
      clk_out_select == ofc_clk_mode_t'({$past(clk_out_select_bit1),
                                         $past(clk_out_select_bit0)});
  endproperty
  a_strap: assert property (p_strap)
    else $error("straps not taken after reset");

  property p_irq;
    $rose(flagA) && state_q.intEn[0] |-> irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt missed a channel A event");

endmodule

/* File: ofc_host_model.sv */
// Host-side receiver that measures a clock arriving on one pin
`timescale 1ns/100ps
module ofc_host_model (
  input  wire logic        clk,
  input  wire logic        pin,
  output logic [7:0]       period,
  output logic [15:0]      rises
);
  logic       lastPin_q;
  logic [7:0] count_q;

  initial begin
    lastPin_q = 1'b0;
    count_q = 8'h00;
    period = 8'h00;
    rises = 16'h0000;
  end

  // Only listens, so a clock present from power-up is seen unaided
  always @(posedge clk) begin
    lastPin_q <= pin;
    if (pin === 1'b1 && lastPin_q === 1'b0) begin
      period <= count_q + 8'h01;
      count_q <= 8'h00;
      rises <= rises + 16'h0001;
    end else begin
      count_q <= count_q + 8'h01;
    end
  end
endmodule

/* File: test_overrange_flag_clock_out_mux.sv */
// Self-checking bench for the over-range flag and clock-out block
`timescale 1ns/100ps
`include "ofc_cfg.svh"
module test_overrange_flag_clock_out_mux import ofc_pkg::*;;
  logic          clk, rst, sel0, sel1, synthEnable, powerdown;
  logic [8:0]    magA, magB, magC, thr;
  ofc_apb_req_t  req;
  ofc_apb_rsp_t  rsp;
  logic          flagA, flagB, chanC, refOut, irq, flagB1, chanC1;
  logic [7:0]    cPeriod, rPeriod;
  logic [15:0]   cRises, rRises;
  logic [32:0]   readQ[$];
  int            pulseQ[$];
  int            fails, tests_run, cycles, width;
  int            holds[3] = '{0, 1, 5};
  logic [31:0]   cSel[2] = '{32'h1, 32'hB};

  ofc_overrange_mux #(.NUM_CH(4), .MAG_W(9), .HOLD_W(16))
    u_ofc_overrange_mux (
    .clk(clk), .rst(rst), .apbReq(req), .apbRsp(rsp),
    .chanAMagnitude(magA), .chanBMagnitude(magB), .chanCMagnitude(magC),
    .clk_out_select_bit0(sel0), .clk_out_select_bit1(sel1),
    .synthEnable(synthEnable), .powerdown_pin(powerdown),
    .chan_a_range_flag(flagA), .chan_b_range_flag(flagB),
    .chan_c_range_flag_or_clk(chanC), .synth_ref_out(refOut), .irq(irq));

  // Single-channel variant on the same stimulus, for the absent outputs
  ofc_overrange_mux #(.NUM_CH(1), .MAG_W(9), .HOLD_W(16))
    u_ofc_overrange_mux_one (
    .clk(clk), .rst(rst), .apbReq(req), .apbRsp(),
    .chanAMagnitude(magA), .chanBMagnitude(magB), .chanCMagnitude(magC),
    .clk_out_select_bit0(sel0), .clk_out_select_bit1(sel1),
    .synthEnable(synthEnable), .powerdown_pin(powerdown),
    .chan_a_range_flag(), .chan_b_range_flag(flagB1),
    .chan_c_range_flag_or_clk(chanC1), .synth_ref_out(), .irq());

  ofc_host_model u_ofc_host_model_c (
    .clk(clk), .pin(chanC), .period(cPeriod), .rises(cRises));
  ofc_host_model u_ofc_host_model_r (
    .clk(clk), .pin(refOut), .period(rPeriod), .rises(rRises));

  initial clk = 1'b0;
  always #10 clk = ~clk;

  task automatic chk(input string what, input logic [32:0] exp,
                     input logic [32:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic end_of_test;
    $display("Counts: %0d compared, %0d wrong", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // One APB transfer; a read notes its expected {pslverr, prdata}
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [32:0] exp);
    if (!wr) readQ.push_back(exp);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    // Only the bench timeout ends a wait for pready
    do begin
      @(posedge clk);
    end while (rsp.pready !== 1'b1);
    // Release, then one idle cycle so the next call starts cleanly
    req <= '{psel: 1'b0, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk);
  endtask

  // Push one channel over threshold for len cycles, then wait out the hold
  task automatic over(input int ch, input int len, input int hold);
    case (ch)
      0: magA <= thr + 9'h001;
      1: magB <= thr + 9'h001;
      default: magC <= thr + 9'h001;
    endcase
    if (ch == 0) pulseQ.push_back(len - 1 + (hold > 1 ? hold : 1));
    repeat (len) @(posedge clk);
    magA <= 9'h000;
    magB <= 9'h000;
    magC <= 9'h000;
    repeat (len + hold + 4) @(posedge clk);
  endtask

  // Channel C edges, and reference edges when both is set, must stand still while the clock is stopped
  task automatic quiet(input logic both);
    logic [15:0] c0, r0;
    repeat (4) @(posedge clk);
    c0 = cRises;
    r0 = rRises;
    repeat (20) @(posedge clk);
    chk("channel C clock edges", c0, cRises);
    if (both) chk("reference edges", r0, rRises);
  endtask

  // Read results and flag A pulse widths are compared as they appear
  always @(posedge clk) begin
    cycles++;
    if (req.psel && req.penable && rsp.pready === 1'b1 && !req.pwrite) begin
      chk("read word", readQ.size() ? readQ.pop_front() : 33'h0,
          {rsp.pslverr, rsp.prdata});
    end
    if (flagA === 1'b1) begin
      width++;
    end else if (width != 0) begin
      chk("flag A width", pulseQ.size() ? pulseQ.pop_front() : 0, width);
      width = 0;
    end
    if (cycles == 20000) begin
      fails++;
      end_of_test;
    end
  end

  initial begin
    rst = 1'b1;
    req = '0;
    magA = 9'h000;
    magB = 9'h000;
    magC = 9'h000;
    thr = 9'h1FF;
    fails = 0;
    tests_run = 0;
    cycles = 0;
    width = 0;
    sel0 = 1'b1;
    sel1 = 1'b0;
    synthEnable = 1'b1;
    powerdown = 1'b0;
    void'($urandom(32'h859FA9E3));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (20) @(posedge clk);
    chk("strapped clock period", 33'h2, cPeriod);
    chk("reference period", 33'h2, rPeriod);
    $display("Test strapped clock done");

    apb(1'b0, `OFC_ADDR_THRESH, 32'h0, {24'h0, `OFC_RST_THRESH});
    apb(1'b0, `OFC_ADDR_HOLD, 32'h0, {17'h0, `OFC_RST_HOLD});
    apb(1'b0, `OFC_ADDR_INT_EN, 32'h0, 33'h0);
    apb(1'b0, 8'h1C, 32'h0, 33'h100000000);
    $display("Test reset values done");

    thr = 9'($urandom_range(1, 400));
    apb(1'b1, `OFC_ADDR_THRESH, {23'h0, thr}, 33'h0);
    magA <= thr;
    repeat (6) @(posedge clk);
    magA <= 9'h000;
    foreach (holds[i]) begin
      apb(1'b1, `OFC_ADDR_HOLD, 32'(holds[i]), 33'h0);
      over(0, 1, holds[i]);
      over(0, 4, holds[i]);
    end
    $display("Test threshold and hold done");

    apb(1'b1, `OFC_ADDR_INT_CLR, 32'h7, 33'h0);
    apb(1'b1, `OFC_ADDR_INT_EN, 32'h1, 33'h0);
    over(1, 1, 5);
    chk("masked interrupt", 33'h0, irq);
    apb(1'b0, `OFC_ADDR_INT_STAT, 32'h0, 33'h2);
    over(0, 1, 5);
    chk("enabled interrupt", 33'h1, irq);
    apb(1'b0, `OFC_ADDR_INT_STAT, 32'h0, 33'h3);
    apb(1'b1, `OFC_ADDR_INT_CLR, 32'h1, 33'h0);
    repeat (2) @(posedge clk);
    chk("cleared interrupt", 33'h0, irq);
    $display("Test interrupt done");

    for (int code = 1; code < 4; code++) begin
      apb(1'b1, `OFC_ADDR_CLKCTL, 32'(code * 2 + 1), 33'h0);
      repeat (20) @(posedge clk);
      chk("clock C period", 33'(2 << (code - 1)), cPeriod);
    end
    apb(1'b0, `OFC_ADDR_FLAGS, 32'h0, 33'h38);
    synthEnable <= 1'b0;
    quiet(1'b0);
    synthEnable <= 1'b1;
    powerdown <= 1'b1;
    quiet(1'b1);
    powerdown <= 1'b0;
    $display("Test clock out done");

    foreach (cSel[i]) begin
      apb(1'b1, `OFC_ADDR_CLKCTL, cSel[i], 33'h0);
      magC <= thr + 9'h001;
      magB <= thr + 9'h001;
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk("flag on C pin", 33'h1, chanC);
      chk("flag on B pin", 33'h1, flagB);
      chk("single variant B pin", 33'h0, flagB1);
      chk("single variant C pin", 33'h0, chanC1);
      @(posedge clk);
      magC <= 9'h000;
      magB <= 9'h000;
      repeat (10) @(posedge clk);
      @(negedge clk);
      chk("flag on C pin idle", 33'h0, chanC);
      @(posedge clk);
    end
    $display("Test channel C flag done");
    end_of_test;
  end
endmodule
